// file: src/slpl_pkg.sv
/*
 * constants, field layout, command codes, register map and timing
 * for the supply-line programming link.
 * assumes a 25 MHz core clock; all cycle counts derive from it.
 */
package slpl_pkg;

	localparam int CLK_MHZ    = 25;
	localparam int NS_PER_US  = 1000;
	localparam int PCT_FULL   = 100;

	// ***************************************************************
	// telegram layout
	// ***************************************************************
	localparam int CMD_W       = 3;
	localparam int ADR_W       = 4;
	localparam int DAT_W       = 14;
	localparam int CNT_W       = 17;
	localparam int ACT_W       = 13;
	localparam int NBIT_W      = 5;
	localparam int HDR_BITS    = 9;
	localparam int WR_BITS     = 24;
	localparam int TX_W        = 16;
	localparam int TX_RD_BITS  = 16;
	localparam int TX_ACK_BITS = 1;
	localparam int HDR_CP      = 5;
	localparam int HDR_AP      = 0;
	localparam int DP_POS      = 0;
	localparam int KEY_W       = 12;
	localparam int BOUND_SHIFT = 3;
	localparam int ONE_PCT     = 65;

	// ***************************************************************
	// timing, in ns as specified
	// ***************************************************************
	localparam int HOST_BIT_PERIOD_MIN_NS  = 1_700_000;
	localparam int HOST_BIT_PERIOD_MAX_NS  = 1_800_000;
	localparam int REPLY_BIT_PERIOD_NS     = 3_000_000;
	localparam int PROGRAM_VOLTAGE_DELAY_NS = 1_000_000;
	localparam int PROG_RISE_MAX_NS        = 1_000_000;
	localparam int SELECT_PULSE_MIN_NS     = 50_000;
	localparam int SELECT_PULSE_MAX_NS     = 200_000;

	function automatic int ns2cyc_up(input int ns);
		return (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
	endfunction

	function automatic int ns2cyc_dn(input int ns);
		return (ns * CLK_MHZ) / NS_PER_US;
	endfunction

	// ***************************************************************
	// commands and registers
	// ***************************************************************
	localparam logic [CMD_W-1:0] CMD_READ   = 3'h2;
	localparam logic [CMD_W-1:0] CMD_WRITE  = 3'h3;
	localparam logic [CMD_W-1:0] CMD_BURN   = 3'h4;
	localparam logic [CMD_W-1:0] CMD_ERASE  = 3'h5;
	localparam logic [CMD_W-1:0] CMD_FLOCK  = 3'h6;
	localparam logic [CMD_W-1:0] CMD_LOCK   = 3'h7;

	localparam logic [ADR_W-1:0] ADR_CLOW   = 4'h1;
	localparam logic [ADR_W-1:0] ADR_CHIGH  = 4'h2;
	localparam logic [ADR_W-1:0] ADR_QUIET  = 4'h3;
	localparam logic [ADR_W-1:0] ADR_SENS   = 4'h4;
	localparam logic [ADR_W-1:0] ADR_MODE   = 4'h5;
	localparam logic [ADR_W-1:0] ADR_LOCK   = 4'h6;
	localparam logic [ADR_W-1:0] ADR_ADC    = 4'h7;
	localparam logic [ADR_W-1:0] ADR_OFFS   = 4'h8;
	localparam logic [ADR_W-1:0] ADR_OSC    = 4'h9;
	localparam logic [ADR_W-1:0] ADR_TC     = 4'hB;
	localparam logic [ADR_W-1:0] ADR_TCSQ   = 4'hC;
	localparam logic [ADR_W-1:0] ADR_SPEC   = 4'hD;
	localparam logic [ADR_W-1:0] ADR_FLOCK  = 4'hE;
	localparam logic [ADR_W-1:0] ADR_DEACT  = 4'hF;
	localparam logic [KEY_W-1:0] DEACT_KEY  = 12'h80F;

	function automatic logic [ADR_W-1:0] reg_width(input logic [ADR_W-1:0] a);
		case (a)
			ADR_CLOW:  return 4'hA;
			ADR_CHIGH: return 4'hB;
			ADR_QUIET: return 4'hB;
			ADR_SENS:  return 4'hE;
			ADR_MODE:  return 4'h6;
			ADR_LOCK:  return 4'h1;
			ADR_ADC:   return 4'hE;
			ADR_OFFS:  return 4'h4;
			ADR_OSC:   return 4'h5;
			ADR_TC:    return 4'h6;
			ADR_TCSQ:  return 4'h5;
			ADR_SPEC:  return 4'h6;
			ADR_FLOCK: return 4'h1;
			ADR_DEACT: return 4'hC;
			default:   return 4'h0;
		endcase
	endfunction

endpackage

// file: src/slpl_regmem.sv
/*
 * working registers and their nonvolatile image.
 * assumes single writer; erase and burn act on all words at once.
 */
`timescale 1ns/100ps
module slpl_regmem #(
	parameter int DW = 14,
	parameter int AW = 4
)(
	// clock and reset
	input  logic          clk_i,
	input  logic          rst_i,
	// write port
	input  logic          wr_en_i,
	input  logic [AW-1:0] wr_addr_i,
	input  logic [DW-1:0] wr_data_i,
	// telegram read port
	input  logic          rd_en_i,
	input  logic [AW-1:0] rd_addr_i,
	output logic [DW-1:0] rd_data_o,
	// nonvolatile operations and readout
	input  logic          erase_i,
	input  logic          burn_i,
	input  logic [AW-1:0] nv_addr_i,
	output logic [DW-1:0] nv_data_o
);

	logic [DW-1:0] ram_r [2**AW];
	logic [DW-1:0] nv_r  [2**AW];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 2**AW; i++) ram_r[i] <= '0;
		end else if (wr_en_i) begin
			ram_r[wr_addr_i] <= wr_data_i;
		end
	end

	// reset stands for a blank part here; the image survives no reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 2**AW; i++) nv_r[i] <= '0;
		end else if (erase_i) begin
			for (int i = 0; i < 2**AW; i++) nv_r[i] <= '0;
		end else if (burn_i) begin
			for (int i = 0; i < 2**AW; i++) nv_r[i] <= ram_r[i];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= '0;
			nv_data_o <= '0;
		end else begin
			if (rd_en_i) begin
				rd_data_o <= ram_r[rd_addr_i];
			end
			nv_data_o <= nv_r[nv_addr_i];
		end
	end

endmodule

// file: src/slpl_link.sv
/*
 * device end of the supply-line programming link: telegram receiver,
 * command execution, reply transmitter and activate-pulse detector.
 * assumes supply and pin levels already digitised and synchronous.
 */
`timescale 1ns/100ps
module slpl_link
	import slpl_pkg::*;
#(
	parameter logic [CNT_W-1:0] SYNC_MIN_CYC  = CNT_W'(ns2cyc_up(HOST_BIT_PERIOD_MIN_NS)),
	parameter logic [CNT_W-1:0] SYNC_MAX_CYC  = CNT_W'(ns2cyc_dn(HOST_BIT_PERIOD_MAX_NS)),
	parameter logic [CNT_W-1:0] REPLY_CYC     = CNT_W'(ns2cyc_dn(REPLY_BIT_PERIOD_NS)),
	parameter logic [CNT_W-1:0] VWAIT_CYC     =
		CNT_W'(ns2cyc_dn(PROGRAM_VOLTAGE_DELAY_NS + PROG_RISE_MAX_NS)),
	parameter logic [ACT_W-1:0] SEL_MAX_CYC   = ACT_W'(ns2cyc_dn(SELECT_PULSE_MAX_NS))
)(
	// clock and reset
	input  logic             mclk_i,
	input  logic             rst_i,
	// supply line, digitised
	input  logic             supply_level_i,
	input  logic             prog_level_i,
	// output pin
	input  logic             out_pin_i,
	output logic             reply_o,
	output logic             reply_oe_o,
	// sensor side
	input  logic [DAT_W-1:0] adc_value_i,
	input  logic [ADR_W-1:0] cfg_addr_i,
	output logic [DAT_W-1:0] cfg_data_o,
	output logic             deactivated_o,
	output logic             analog_mode_o,
	output logic             factory_lock_o,
	output logic             burn_nonvolatile_o
);

	localparam logic [ACT_W-1:0] SEL_MIN_CYC = ACT_W'(ns2cyc_up(SELECT_PULSE_MIN_NS));
	localparam logic [CNT_W-1:0] ONE_CYC     = CNT_W'(int'(REPLY_CYC) * ONE_PCT / PCT_FULL);
	localparam logic [CNT_W-1:0] LAST_CYC    = REPLY_CYC - CNT_W'(1);

	typedef enum {ST_IDLE, ST_SYNC, ST_BITS, ST_EXEC, ST_LOAD, ST_REPLY, ST_TXEND,
		ST_WAITV, ST_BURN} slpl_state_e;

	slpl_state_e       state_r;
	logic              sup_q_r;
	logic [CNT_W-1:0]  cnt_r;
	logic [CNT_W-1:0]  host_bit_period_r;
	logic              mid_r;
	logic [NBIT_W-1:0] nbit_r;
	logic [NBIT_W-1:0] tleft_r;
	logic [WR_BITS-1:0] sh_r;
	logic [CMD_W-1:0]  cmd_r;
	logic [ADR_W-1:0]  adr_r;
	logic [TX_W-1:0]   tx_sh_r;
	logic              deact_r;
	logic              full_lock_r;
	logic              flock_r;
	logic              pin_q_r;
	logic [ACT_W-1:0]  act_cnt_r;

	// ***************************************************************
	// telegram decode
	// ***************************************************************
	logic               edge_w;
	logic [CNT_W-1:0]   bound_w;
	logic [CNT_W-1:0]   late_w;
	logic [WR_BITS-1:0] sh_nxt;
	logic [HDR_BITS-1:0] hdr_w;
	logic [CMD_W-1:0]   cmd_w;
	logic [ADR_W-1:0]   adr_w;
	logic [DAT_W-1:0]   payload_bits_w;
	logic               command_parity_w;
	logic               select_parity_w;
	logic               payload_parity_w;
	logic               par_ok_w;
	logic               wr_able_w;
	logic               rd_able_w;
	logic               ok_w;
	logic [ADR_W-1:0]   wid_w;
	logic [DAT_W:0]     mask_w;
	logic [DAT_W-1:0]   mem_rd_w;
	logic [DAT_W-1:0]   rd_val_w;
	logic [DAT_W-1:0]   rd_field_w;
	logic               act_hit_w;
	logic               burn_go_w;

	assign edge_w  = supply_level_i ^ sup_q_r;
	assign bound_w = host_bit_period_r - (host_bit_period_r >> BOUND_SHIFT);
	assign late_w  = host_bit_period_r + (host_bit_period_r >> BOUND_SHIFT);
	assign sh_nxt  = {sh_r[WR_BITS-2:0], mid_r};
	assign hdr_w   = (nbit_r == NBIT_W'(HDR_BITS)) ? sh_r[HDR_BITS-1:0]
		: sh_r[WR_BITS-1 -: HDR_BITS];
	assign cmd_w   = hdr_w[HDR_BITS-1 -: CMD_W];
	assign adr_w   = hdr_w[HDR_CP-1:HDR_AP+1];
	assign command_parity_w = hdr_w[HDR_CP];
	assign select_parity_w  = hdr_w[HDR_AP];
	assign payload_bits_w   = sh_r[DAT_W:DP_POS+1];
	assign payload_parity_w = sh_r[DP_POS];

	assign par_ok_w = (command_parity_w == ^(~cmd_w))
		&& (select_parity_w == ^(~adr_w))
		&& (cmd_w != CMD_WRITE || payload_parity_w == ~^(~payload_bits_w));

	assign wr_able_w = adr_w inside {ADR_CLOW, ADR_CHIGH, ADR_QUIET, ADR_SENS,
		ADR_MODE, ADR_TC, ADR_TCSQ, ADR_DEACT};
	assign rd_able_w = (reg_width(adr_w) != '0) && (adr_w != ADR_DEACT);

	// deactivated or fully locked parts stay silent
	assign ok_w = par_ok_w && !deact_r && !full_lock_r
		&& (cmd_w >= CMD_READ)
		&& (cmd_w != CMD_READ || rd_able_w)
		&& (cmd_w != CMD_WRITE || wr_able_w);

	// ***************************************************************
	// register access
	// ***************************************************************
	assign wid_w  = reg_width(adr_w);
	assign mask_w = ((DAT_W+1)'(1) << wid_w) - (DAT_W+1)'(1);

	always_comb begin
		case (adr_r)
			ADR_LOCK:  rd_val_w = DAT_W'(full_lock_r);
			ADR_FLOCK: rd_val_w = DAT_W'(flock_r);
			ADR_ADC:   rd_val_w = adc_value_i;
			default:   rd_val_w = mem_rd_w;
		endcase
		rd_field_w = rd_val_w << (ADR_W'(DAT_W) - reg_width(adr_r));
	end

	assign burn_go_w = (state_r == ST_WAITV) && prog_level_i;
	assign burn_nonvolatile_o = burn_go_w && (cmd_r == CMD_BURN);

	slpl_regmem #(
		.DW (DAT_W),
		.AW (ADR_W)
	) u_regmem (
		.clk_i     (mclk_i),
		.rst_i     (rst_i),
		.wr_en_i   (state_r == ST_EXEC && ok_w && cmd_w == CMD_WRITE && adr_w != ADR_DEACT),
		.wr_addr_i (adr_w),
		.wr_data_i (payload_bits_w & mask_w[DAT_W-1:0]),
		.rd_en_i   (state_r == ST_EXEC),
		.rd_addr_i (adr_w),
		.rd_data_o (mem_rd_w),
		.erase_i   (burn_go_w && cmd_r == CMD_ERASE),
		.burn_i    (burn_nonvolatile_o),
		.nv_addr_i (cfg_addr_i),
		.nv_data_o (cfg_data_o)
	);

	// ***************************************************************
	// sequencer: receive, execute, reply, programming wait
	// ***************************************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r           <= ST_IDLE;
			// supply idles high; a low reset value would fake a sync edge
			sup_q_r           <= 1'b1;
			cnt_r             <= '0;
			host_bit_period_r <= '0;
			mid_r             <= 1'b0;
			nbit_r            <= '0;
			tleft_r           <= '0;
			sh_r              <= '0;
			cmd_r             <= '0;
			adr_r             <= '0;
		end else begin
			sup_q_r <= supply_level_i;
			case (state_r)
				ST_IDLE: begin
					cnt_r <= '0;
					if (edge_w) begin
						state_r <= ST_SYNC;
					end
				end
				ST_SYNC: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (edge_w) begin
						cnt_r <= '0;
						// an out-of-range sync edge starts a fresh sync bit
						if (cnt_r >= SYNC_MIN_CYC && cnt_r <= SYNC_MAX_CYC) begin
							host_bit_period_r <= cnt_r;
							state_r           <= ST_BITS;
							nbit_r            <= '0;
							mid_r             <= 1'b0;
						end
					end else if (cnt_r > SYNC_MAX_CYC) begin
						state_r <= ST_IDLE;
					end
				end
				ST_BITS: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (edge_w && cnt_r < bound_w) begin
						mid_r <= 1'b1;
						if (mid_r) begin
							state_r <= ST_IDLE;
						end
					end else if (edge_w) begin
						sh_r   <= sh_nxt;
						nbit_r <= nbit_r + NBIT_W'(1);
						cnt_r  <= '0;
						mid_r  <= 1'b0;
						if ((nbit_r == NBIT_W'(HDR_BITS - 1)
							&& sh_nxt[HDR_BITS-1 -: CMD_W] != CMD_WRITE)
							|| nbit_r == NBIT_W'(WR_BITS - 1)) begin
							state_r <= ST_EXEC;
						end
					end else if (cnt_r > late_w) begin
						state_r <= ST_IDLE;
					end
				end
				ST_EXEC: begin
					cmd_r   <= cmd_w;
					adr_r   <= adr_w;
					cnt_r   <= '0;
					tleft_r <= (cmd_w == CMD_READ) ? NBIT_W'(TX_RD_BITS)
						: NBIT_W'(TX_ACK_BITS);
					if (!ok_w) begin
						state_r <= ST_IDLE;
					end else if (cmd_w == CMD_READ) begin
						state_r <= ST_LOAD;
					end else begin
						state_r <= ST_REPLY;
					end
				end
				ST_LOAD: begin
					state_r <= ST_REPLY;
				end
				ST_REPLY: begin
					cnt_r <= (cnt_r == LAST_CYC) ? '0 : cnt_r + CNT_W'(1);
					if (cnt_r == LAST_CYC) begin
						tleft_r <= tleft_r - NBIT_W'(1);
						if (tleft_r == NBIT_W'(1)) begin
							state_r <= ST_TXEND;
						end
					end
				end
				ST_TXEND: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (cnt_r == LAST_CYC) begin
						cnt_r   <= '0;
						state_r <= (cmd_r == CMD_BURN || cmd_r == CMD_ERASE)
							? ST_WAITV : ST_IDLE;
					end
				end
				ST_WAITV: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (prog_level_i) begin
						state_r <= ST_BURN;
					end else if (cnt_r >= VWAIT_CYC) begin
						state_r <= ST_IDLE;
					end
				end
				ST_BURN: begin
					// the host bounds the interval; telegrams wait for it to end
					if (!prog_level_i) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ***************************************************************
	// reply transmitter
	// ***************************************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			reply_o    <= 1'b0;
			reply_oe_o <= 1'b0;
			tx_sh_r    <= '0;
		end else begin
			case (state_r)
				ST_EXEC: begin
					tx_sh_r <= '0;
				end
				ST_LOAD: begin
					tx_sh_r <= {1'b0, rd_field_w, ~^(~rd_field_w)};
				end
				ST_REPLY: begin
					reply_oe_o <= 1'b1;
					if (cnt_r == '0) begin
						reply_o <= ~reply_o;
					end else if (cnt_r == ONE_CYC && tx_sh_r[TX_W-1]) begin
						reply_o <= ~reply_o;
					end
					if (cnt_r == LAST_CYC) begin
						tx_sh_r <= tx_sh_r << 1;
					end
				end
				ST_TXEND: begin
					// closing edge, held one period so it reads as a boundary
					if (cnt_r == '0) begin
						reply_o <= ~reply_o;
					end
					if (cnt_r == LAST_CYC) begin
						reply_oe_o <= 1'b0;
						reply_o    <= 1'b0;
					end
				end
				default: begin
					reply_oe_o <= 1'b0;
				end
			endcase
		end
	end

	// ***************************************************************
	// locks and selection
	// ***************************************************************
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			full_lock_r <= 1'b0;
			flock_r     <= 1'b0;
		end else if (state_r == ST_EXEC && ok_w) begin
			if (cmd_w == CMD_LOCK) begin
				full_lock_r <= 1'b1;
			end
			if (cmd_w == CMD_FLOCK) begin
				flock_r <= 1'b1;
			end
		end
	end

	assign act_hit_w = pin_q_r && !out_pin_i && !reply_oe_o
		&& act_cnt_r >= SEL_MIN_CYC && act_cnt_r <= SEL_MAX_CYC;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_q_r   <= 1'b0;
			act_cnt_r <= '0;
			deact_r   <= 1'b0;
		end else begin
			pin_q_r <= out_pin_i;
			if (!out_pin_i || reply_oe_o) begin
				act_cnt_r <= '0;
			end else if (act_cnt_r != '1) begin
				act_cnt_r <= act_cnt_r + ACT_W'(1);
			end
			if (state_r == ST_EXEC && ok_w && cmd_w == CMD_WRITE && adr_w == ADR_DEACT
				&& payload_bits_w[KEY_W-1:0] == DEACT_KEY) begin
				deact_r <= 1'b1;
			end else if (act_hit_w) begin
				deact_r <= 1'b0;
			end
		end
	end

	assign deactivated_o  = deact_r;
	assign analog_mode_o  = full_lock_r;
	assign factory_lock_o = flock_r;

	// ***************************************************************
	// checks
	// ***************************************************************
	sync_period_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_r == ST_SYNC && edge_w && cnt_r >= SYNC_MIN_CYC && cnt_r <= SYNC_MAX_CYC)
		|=> (state_r == ST_BITS && host_bit_period_r == $past(cnt_r)))
		else $error("bit period not taken from sync");
	bad_telegram_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_r == ST_EXEC && !ok_w) |=> (state_r == ST_IDLE) ##1 !reply_oe_o)
		else $error("rejected telegram was answered");
	cmd_parity_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_r == ST_EXEC && ok_w) |-> (command_parity_w == ((cmd_w == 3'h0)
		|| (cmd_w == 3'h3) || (cmd_w == 3'h5) || (cmd_w == 3'h6))))
		else $error("command parity accepted wrongly");
	read_len_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_r == ST_EXEC && ok_w && cmd_w == CMD_READ)
		|=> (tleft_r == NBIT_W'(TX_RD_BITS)) ##1 (state_r == ST_REPLY))
		else $error("read reply length wrong");
	reply_edges_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_r == ST_REPLY && $past(state_r) == ST_REPLY && reply_o != $past(reply_o))
		|-> ($past(cnt_r) == '0 || $past(cnt_r) == ONE_CYC))
		else $error("reply edge off the bit grid");
	deact_key_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_r == ST_EXEC && ok_w && cmd_w == CMD_WRITE && adr_w == ADR_DEACT
		&& payload_bits_w[KEY_W-1:0] == DEACT_KEY) |=> deactivated_o)
		else $error("deactivate key ignored");
	locks_stay_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		($past(factory_lock_o) |-> factory_lock_o)
		and ($past(analog_mode_o) |-> analog_mode_o))
		else $error("lock bit cleared");
	select_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_r == ST_EXEC && deactivated_o) |=> (state_r == ST_IDLE))
		else $error("deactivated part executed");

endmodule

// file: tb/slpl_prog.sv
/*
 * behavioural programmer: sends telegrams on the supply, decodes replies,
 * raises the programming level and makes select pulses.
 * assumes its tasks are called at the falling clock edge.
 */
`timescale 1ns/100ps
module slpl_prog
	import slpl_pkg::*;
#(
	parameter int P  = 70,
	parameter int QM = 400
)(
	// clock and reply pin
	input  logic mclk_i,
	input  logic reply_i,
	input  logic reply_oe_i,
	// supply and select drive
	output logic supply_o,
	output logic prog_o,
	output logic pulse_o
);
	// ****************************************
	// programmer tasks
	// ****************************************
	initial begin
		supply_o = 1'b1;
		prog_o = 1'b0;
		pulse_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// flip spoils the command parity on purpose
	task automatic send(input logic [2:0] c, input logic [3:0] a, input logic [13:0] d,
			input logic flip);
		logic [23:0] f;
		f = {c, ~^c ^ flip, a, ^a, d, ~^d};
		tick(1);
		supply_o = ~supply_o;
		tick(P);
		supply_o = ~supply_o;
		for (int i = 0; i < ((c == CMD_WRITE) ? 24 : 9); i++) begin
			tick(f[23-i] ? P*65/100 : P);
			if (f[23-i]) begin
				supply_o = ~supply_o;
				tick(P - P*65/100);
			end
			supply_o = ~supply_o;
		end
	endtask
	// reply bits are judged against the measured acknowledge length
	task automatic recv(input int nb, output logic [15:0] d, output int q, output logic ok);
		int c;
		logic l;
		d = '0;
		q = 0;
		for (c = 0; c < 4*QM && !reply_oe_i; c++) tick(1);
		ok = reply_oe_i;
		if (ok) begin
			l = reply_i;
			for (q = 0; q < QM && reply_i == l; q++) tick(1);
			for (int i = 0; i < nb; i++) begin
				l = reply_i;
				for (c = 0; c < QM && reply_i == l; c++) tick(1);
				d = {d[14:0], c < q*7/8};
				l = reply_i;
				if (d[0]) for (; c < QM && reply_i == l; c++) tick(1);
			end
			for (c = 0; c < 3*QM && reply_oe_i; c++) tick(1);
		end
	endtask
	// scaled delay and hold, the real ones would make the run too long
	task automatic raise_prog();
		tick(20);
		prog_o = 1'b1;
		tick(150);
		prog_o = 1'b0;
		tick(10);
	endtask
	task automatic act(input int n);
		pulse_o = 1'b1;
		tick(n);
		pulse_o = 1'b0;
		tick(5);
	endtask
endmodule

// file: tb/testbench.sv
/*
 * self-checking bench: write, read, refusals, store, select, locks.
 * assumes shortened timing parameters set on the instance below.
 */
`timescale 1ns/100ps
module testbench;
	import slpl_pkg::*;
	// ****************************************
	// design, programmer and checks
	// ****************************************
	logic             mclk_i    = 1'b0;
	logic             rst_i     = 1'b1;
	logic             supply;
	logic             prog;
	logic             pulse;
	logic             reply;
	logic             reply_oe;
	logic [DAT_W-1:0] cfg_data;
	logic [ADR_W-1:0] cfg_addr  = ADR_MODE;
	logic [DAT_W-1:0] adc       = 14'h1234;
	logic             deact;
	logic             amode;
	logic             flock;
	logic             burn;
	logic [15:0]      d;
	int               q;
	logic             ok;
	int               burns     = 0;
	int               error_cnt = 0;
	int               tests_run = 0;
	always #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (burn === 1'b1) burns++;
	slpl_link #(
		.SYNC_MIN_CYC(17'h3C), .SYNC_MAX_CYC(17'h50), .REPLY_CYC(17'h64)
	) u_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .supply_level_i(supply), .prog_level_i(prog),
		.out_pin_i(reply_oe ? reply : pulse), .reply_o(reply), .reply_oe_o(reply_oe),
		.adc_value_i(adc), .cfg_addr_i(cfg_addr), .cfg_data_o(cfg_data),
		.deactivated_o(deact), .analog_mode_o(amode), .factory_lock_o(flock),
		.burn_nonvolatile_o(burn)
	);
	slpl_prog u_prog (
		.mclk_i(mclk_i), .reply_i(reply), .reply_oe_i(reply_oe),
		.supply_o(supply), .prog_o(prog), .pulse_o(pulse)
	);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// a reply that is due but never comes ends the run
	task automatic tr(input logic [2:0] c, input logic [3:0] a, input logic [13:0] v,
			input logic flip, input int nb, input logic exp);
		u_prog.send(c, a, v, flip);
		u_prog.recv(nb, d, q, ok);
		check(ok, exp);
		if (exp && !ok) conclude();
	endtask
	task automatic sc_write_read();
		tr(CMD_WRITE, ADR_MODE, 14'h3F2A, 1'b0, 0, 1'b1);
		check(q, 100);
		tr(CMD_WRITE, ADR_CLOW, 14'h3FFF, 1'b0, 0, 1'b1);
		tr(CMD_READ, ADR_MODE, 14'h0, 1'b0, 15, 1'b1);
		check(d[14:9], 6'h2A);
		check(d[0], ~^d[14:1]);
		tr(CMD_READ, ADR_ADC, 14'h0, 1'b0, 15, 1'b1);
		check(d, {1'b0, 14'h1234, ~^14'h1234});
		adc = 14'h0ABC;
		tr(CMD_READ, ADR_ADC, 14'h0, 1'b0, 15, 1'b1);
		check(d, {1'b0, 14'h0ABC, ~^14'h0ABC});
	endtask
	task automatic sc_refuse();
		tr(CMD_READ, ADR_MODE, 14'h0, 1'b1, 15, 1'b0);
		for (int k = 0; k < 2; k++)
			tr(3'(k), ADR_MODE, 14'h0, 1'b0, 15, 1'b0);
	endtask
	task automatic sc_store();
		tr(CMD_ERASE, ADR_MODE, 14'h0, 1'b0, 0, 1'b1);
		u_prog.raise_prog();
		check(burns, 0);
		tr(CMD_BURN, ADR_MODE, 14'h0, 1'b0, 0, 1'b1);
		u_prog.raise_prog();
		check(burns, 1);
		check(cfg_data, 14'h002A);
		cfg_addr = ADR_CLOW;
		repeat (2) @(negedge mclk_i);
		check(cfg_data, 14'h03FF);
	endtask
	task automatic sc_select();
		tr(CMD_WRITE, ADR_DEACT, 14'h080F, 1'b0, 0, 1'b1);
		check(deact, 1'b1);
		tr(CMD_READ, ADR_MODE, 14'h0, 1'b0, 15, 1'b0);
		u_prog.act(2500);
		check(deact, 1'b0);
		tr(CMD_READ, ADR_MODE, 14'h0, 1'b0, 15, 1'b1);
	endtask
	task automatic sc_lock();
		tr(CMD_FLOCK, ADR_FLOCK, 14'h0, 1'b0, 0, 1'b1);
		check(flock, 1'b1);
		tr(CMD_LOCK, ADR_LOCK, 14'h0, 1'b0, 0, 1'b1);
		check(amode, 1'b1);
		tr(CMD_READ, ADR_MODE, 14'h0, 1'b0, 15, 1'b0);
	endtask
	initial begin
		repeat (12) @(negedge mclk_i);
		rst_i = 1'b0;
		sc_write_read();
		sc_refuse();
		sc_store();
		sc_select();
		sc_lock();
		conclude();
	end
	initial begin
		repeat (60000) @(posedge mclk_i);
		error_cnt++;
		conclude();
	end
endmodule
